// ==== include/otpp_consts.vh ====
// timing and supply-select constants for the one-time-programmable memory programmer
`ifndef OTPP_CONSTS_VH
`define OTPP_CONSTS_VH
`define OTPP_CLK_MHZ 50
`define OTPP_PULSE_NOM_US 100
`define OTPP_PULSE_CYC (`OTPP_PULSE_NOM_US * `OTPP_CLK_MHZ)
`define OTPP_SETUP_US 2
`define OTPP_SETUP_CYC (`OTPP_SETUP_US * `OTPP_CLK_MHZ)
`define OTPP_RETRY_MAX 4'ha
`define OTPP_SUP_OFF 2'h0
`define OTPP_SUP_NOM 2'h1
`define OTPP_SUP_HIGH 2'h2
`endif

// ==== logic/otpp_programmer.v ====
// programmer that burns, verifies and identifies a 32K x 8 one-time-programmable memory
// What this block does
// - chip enable pulse lasts 95 to 105 us
// - core supply up first, down last
// - start sequence at the first address
// - core 6.5V, program 13.0V while programming
// - first pass: one pulse per address
// - second pass: up to ten pulses, verify each
// - ten failed extra pulses fail the part
// - verified byte advances, loop covers every address
// - both supplies to 5.0V before final check
// - final read-back passes only if all match
// - id mode raises id line during read
`timescale 1ns/1ps
`include "otpp_consts.vh"
module otpp_programmer #(
  parameter AW = 15,
  parameter PULSE_CYC = `OTPP_PULSE_CYC,
  parameter SETUP_CYC = `OTPP_SETUP_CYC
)(
  // clock and reset
  input wire core_clk_i,
  input wire sys_rst_i,
  // command
  input wire prog_start_i,
  input wire id_start_i,
  input wire [7:0] src_data_i,
  // device pins
  output reg [AW-1:0] addr_o,
  output reg [7:0] data_o,
  output reg data_oe_o,
  input wire [7:0] data_out_lines_i,
  output reg chip_en_n_o,
  output reg out_gate_n_o,
  output reg id_mode_line_o,
  output reg [1:0] core_sup_o,
  output reg [1:0] prog_sup_o,
  // status
  output reg [AW-1:0] src_addr_o,
  output reg busy_o,
  output reg done_o,
  output reg pass_o,
  output reg [7:0] maker_code_o,
  output reg [7:0] part_code_o
);
  localparam S_IDLE = 11'h001;
  localparam S_PWRUP = 11'h002;
  localparam S_P1SET = 11'h004;
  localparam S_P1PUL = 11'h008;
  localparam S_VREAD = 11'h010;
  localparam S_VPUL = 11'h020;
  localparam S_PWRDN = 11'h040;
  localparam S_FREAD = 11'h080;
  localparam S_IDRD = 11'h100;
  localparam S_END = 11'h200;
  localparam S_SUP2 = 11'h400;
  localparam CW = 16;
  reg [10:0] state;
  reg [CW-1:0] cnt;
  reg [3:0] tries;
  reg pass1;
  reg [7:0] din_s0;
  reg [7:0] din_s1;
  wire cnt_done = (cnt == {CW{1'b0}});
  wire at_last = (addr_o == {AW{1'b1}});
  wire match = (din_s1 == src_data_i);
  always @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      din_s0 <= 8'h00;
      din_s1 <= 8'h00;
    end
    else
    begin
      din_s0 <= data_out_lines_i;
      din_s1 <= din_s0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= S_IDLE;
      cnt <= {CW{1'b0}};
      tries <= 4'h0;
      pass1 <= 1'b0;
      addr_o <= {AW{1'b0}};
      src_addr_o <= {AW{1'b0}};
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      chip_en_n_o <= 1'b1;
      out_gate_n_o <= 1'b1;
      id_mode_line_o <= 1'b0;
      core_sup_o <= `OTPP_SUP_NOM;
      prog_sup_o <= `OTPP_SUP_NOM;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      pass_o <= 1'b0;
      maker_code_o <= 8'h00;
      part_code_o <= 8'h00;
    end
    else
    begin
      src_addr_o <= addr_o;
      if (!cnt_done)
        cnt <= cnt - 1'b1;
      case (state)
        S_IDLE:
        begin
          if (prog_start_i)
          begin
            addr_o <= {AW{1'b0}};
            core_sup_o <= `OTPP_SUP_HIGH;
            busy_o <= 1'b1;
            done_o <= 1'b0;
            pass_o <= 1'b0;
            pass1 <= 1'b1;
            cnt <= SETUP_CYC[CW-1:0];
            state <= S_PWRUP;
          end
          else if (id_start_i)
          begin
            addr_o <= {AW{1'b0}};
            id_mode_line_o <= 1'b1;
            chip_en_n_o <= 1'b0;
            out_gate_n_o <= 1'b0;
            busy_o <= 1'b1;
            done_o <= 1'b0;
            cnt <= SETUP_CYC[CW-1:0];
            state <= S_IDRD;
          end
        end
        S_PWRUP:
        begin
          // program supply only after core supply has settled
          if (cnt_done)
          begin
            prog_sup_o <= `OTPP_SUP_HIGH;
            cnt <= SETUP_CYC[CW-1:0];
            state <= S_P1SET;
          end
        end
        S_P1SET:
        begin
          // address and data setup before the pulse
          data_o <= src_data_i;
          data_oe_o <= 1'b1;
          out_gate_n_o <= 1'b1;
          if (cnt_done)
          begin
            chip_en_n_o <= 1'b0;
            cnt <= PULSE_CYC[CW-1:0] - 1'b1;
            state <= S_P1PUL;
          end
        end
        S_P1PUL, S_VPUL:
        begin
          if (cnt_done)
          begin
            chip_en_n_o <= 1'b1;
            cnt <= SETUP_CYC[CW-1:0];
            if (pass1 && !at_last)
            begin
              addr_o <= addr_o + 1'b1;
              state <= S_P1SET;
            end
            else
            begin
              if (pass1)
                addr_o <= {AW{1'b0}};
              pass1 <= 1'b0;
              tries <= pass1 ? 4'h0 : tries;
              state <= S_VREAD;
            end
          end
        end
        S_VREAD:
        begin
          // bus released, then gate asserted with enable to read back
          data_oe_o <= 1'b0;
          if (cnt == SETUP_CYC[CW-1:0] - 1'b1)
          begin
            chip_en_n_o <= 1'b0;
            out_gate_n_o <= 1'b0;
          end
          if (cnt_done)
          begin
            chip_en_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            cnt <= SETUP_CYC[CW-1:0];
            if (match)
            begin
              tries <= 4'h0;
              if (at_last)
              begin
                core_sup_o <= `OTPP_SUP_HIGH;
                prog_sup_o <= `OTPP_SUP_NOM;
                state <= S_PWRDN;
              end
              else
              begin
                addr_o <= addr_o + 1'b1;
                state <= S_VREAD;
              end
            end
            else if (tries == `OTPP_RETRY_MAX)
            begin
              prog_sup_o <= `OTPP_SUP_NOM;
              state <= S_END;
            end
            else
            begin
              tries <= tries + 1'b1;
              data_o <= src_data_i;
              data_oe_o <= 1'b1;
              state <= S_SUP2;
            end
          end
        end
        S_SUP2:
        begin
          if (cnt_done)
          begin
            chip_en_n_o <= 1'b0;
            cnt <= PULSE_CYC[CW-1:0] - 1'b1;
            state <= S_VPUL;
          end
        end
        S_PWRDN:
        begin
          // core supply drops only after program supply
          if (cnt_done)
          begin
            core_sup_o <= `OTPP_SUP_NOM;
            addr_o <= {AW{1'b0}};
            pass_o <= 1'b1;
            cnt <= SETUP_CYC[CW-1:0];
            state <= S_FREAD;
          end
        end
        S_FREAD:
        begin
          chip_en_n_o <= 1'b0;
          out_gate_n_o <= 1'b0;
          if (cnt_done)
          begin
            chip_en_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            cnt <= SETUP_CYC[CW-1:0];
            if (!match)
              pass_o <= 1'b0;
            if (at_last)
              state <= S_END;
            else
              addr_o <= addr_o + 1'b1;
          end
        end
        S_IDRD:
        begin
          if (cnt_done)
          begin
            cnt <= SETUP_CYC[CW-1:0];
            if (addr_o[0])
            begin
              part_code_o <= din_s1;
              chip_en_n_o <= 1'b1;
              out_gate_n_o <= 1'b1;
              id_mode_line_o <= 1'b0;
              addr_o <= {AW{1'b0}};
              state <= S_END;
            end
            else
            begin
              maker_code_o <= din_s1;
              addr_o <= {{(AW-1){1'b0}}, 1'b1};
            end
          end
        end
        S_END:
        begin
          // core supply held until program supply has fallen
          if (cnt_done)
          begin
            core_sup_o <= `OTPP_SUP_NOM;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/otpp_programmer_monitor.sv ====
// assertions on the programmer's memory pins
`timescale 1ns/1ps
module otpp_mon #(parameter AW = 3, parameter PULSE_CYC = 8)(
  // clock, reset, commands
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire prog_start_i,
  input wire id_start_i,
  // memory pins
  input wire [AW-1:0] addr_o,
  input wire data_oe_o,
  input wire chip_en_n_o,
  input wire out_gate_n_o,
  input wire id_mode_line_o,
  input wire [1:0] core_sup_o,
  input wire [1:0] prog_sup_o,
  // status
  input wire busy_o,
  input wire done_o,
  input wire pass_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire burn = !chip_en_n_o && out_gate_n_o;
  reg [15:0] pw;
  always @(posedge core_clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      pw <= 16'h0;
    else
      pw <= burn ? pw + 16'h1 : 16'h0;
  property p_pw; burn ##1 !burn |-> pw == PULSE_CYC; endproperty
  a_pw: assert property (p_pw) else $error("pulse width off");
  property p_sup; prog_sup_o <= core_sup_o; endproperty
  a_sup: assert property (p_sup) else $error("supply order");
  property p_first; $rose(busy_o) |-> addr_o == 0; endproperty
  a_first: assert property (p_first) else $error("start address");
  property p_hv; burn |-> core_sup_o == 2'h2 && prog_sup_o == 2'h2; endproperty
  a_hv: assert property (p_hv) else $error("pulse at low supply");
  property p_hold; burn |-> data_oe_o && (!$past(burn) || $stable(addr_o)); endproperty
  a_hold: assert property (p_hold) else $error("pulse data or address");
  property p_rd; !out_gate_n_o |-> !chip_en_n_o && !data_oe_o; endproperty
  a_rd: assert property (p_rd) else $error("read pins");
  property p_id; $rose(id_mode_line_o) |-> $past(id_start_i && !prog_start_i); endproperty
  a_id: assert property (p_id) else $error("id line cause");
  property p_low;
    $fell(prog_sup_o == 2'h2) |-> prog_sup_o == 2'h1 ##[1:20] core_sup_o == 2'h1;
  endproperty
  a_low: assert property (p_low) else $error("supply lowering");
  property p_done; $rose(done_o) |-> core_sup_o == 2'h1 && prog_sup_o == 2'h1; endproperty
  a_done: assert property (p_done) else $error("done at high supply");
  c_pass: cover property ($rose(done_o) && pass_o);
  c_fail: cover property ($rose(done_o) && !pass_o);
  c_id: cover property ($rose(id_mode_line_o));
endmodule
bind otpp_programmer otpp_mon #(.AW(AW), .PULSE_CYC(PULSE_CYC)) mon_u (.*);

// ==== tb/otpp_mem_model.sv ====
// behavioural one-time-programmable memory facing the programmer
`timescale 1ns/1ps
module otpp_mem_model #(parameter MAKER = 8'h5a, parameter PART = 8'ha5)(
  // pins from the programmer
  input wire core_clk_i,
  input wire blank_i,
  input wire [2:0] addr_i,
  input wire [7:0] data_i,
  input wire chip_en_n_i,
  input wire out_gate_n_i,
  input wire id_mode_line_i,
  input wire [1:0] prog_sup_i,
  // slow cell setup and pulse count
  input wire [2:0] weak_addr_i,
  input wire [4:0] weak_need_i,
  output reg [7:0] data_out_lines_o,
  output reg [7:0] pulses_o
);
  reg [7:0] mem [0:7];
  reg [4:0] hits [0:7];
  reg [7:0] last, pd;
  reg [2:0] pa;
  reg burn_q;
  integer i;
  wire burn = !chip_en_n_i && out_gate_n_i && prog_sup_i == 2'h2;
  wire rd = !chip_en_n_i && !out_gate_n_i;
  always @*
    if (rd)
      data_out_lines_o = id_mode_line_i ? (addr_i[0] ? PART : MAKER) : mem[addr_i];
    else
      data_out_lines_o = ~last;
  always @(posedge core_clk_i)
  begin
    burn_q <= burn;
    if (rd)
      last <= data_out_lines_o;
    if (burn)
    begin
      pa <= addr_i;
      pd <= data_i;
    end
    if (blank_i)
    begin
      pulses_o <= 8'h0;
      last <= 8'h0;
      for (i = 0; i < 8; i = i + 1)
      begin
        mem[i] <= 8'hff;
        hits[i] <= 5'h0;
      end
    end
    else if (burn_q && !burn)
    begin
      // slow cell ignores pulses until its count is reached
      pulses_o <= pulses_o + 8'h1;
      hits[pa] <= hits[pa] + 5'h1;
      if (pa != weak_addr_i || hits[pa] + 5'h1 >= weak_need_i)
        mem[pa] <= pd;
    end
  end
endmodule

// ==== tb/otpp_programmer_bench.sv ====
// self-checking bench for the memory programmer
`timescale 1ns/1ps
module otpp_programmer_bench;
  localparam MAKER = 8'h5a; // arbitrary code
  localparam PART = 8'ha5; // arbitrary code
  reg core_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg prog_start_i = 1'b0;
  reg id_start_i = 1'b0;
  reg blank = 1'b1;
  reg [2:0] weak_a = 3'h3;
  reg [4:0] weak_n = 5'h1;
  wire [2:0] addr_o, src_addr_o;
  wire [7:0] data_o, data_out_lines_i, maker_code_o, part_code_o, pulses;
  wire data_oe_o, chip_en_n_o, out_gate_n_o, id_mode_line_o, busy_o, done_o, pass_o;
  wire [1:0] core_sup_o, prog_sup_o;
  wire [7:0] src_data_i = {1'b0, addr_o, 4'h6};
  integer bad_count = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer i;
  always #10 core_clk_i = ~core_clk_i;
  otpp_programmer #(.AW(3), .PULSE_CYC(8), .SETUP_CYC(4)) dut_u (.*);
  otpp_mem_model #(.MAKER(MAKER), .PART(PART)) mdl_u (.core_clk_i(core_clk_i),
    .blank_i(blank), .addr_i(addr_o), .data_i(data_o), .chip_en_n_i(chip_en_n_o),
    .out_gate_n_i(out_gate_n_o), .id_mode_line_i(id_mode_line_o), .prog_sup_i(prog_sup_o),
    .weak_addr_i(weak_a), .weak_need_i(weak_n), .data_out_lines_o(data_out_lines_i),
    .pulses_o(pulses));
  //////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task summarize;
  begin
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // id start always high, program start high when p is set: program must win over id
  task run(input p, input [2:0] a, input [4:0] n);
  begin
    weak_a = a;
    weak_n = n;
    blank = 1'b1;
    @(posedge core_clk_i) #1;
    blank = 1'b0;
    prog_start_i = p;
    id_start_i = 1'b1;
    @(posedge core_clk_i) #1;
    prog_start_i = 1'b0;
    id_start_i = 1'b0;
    wait (done_o === 1'b1);
    #1;
  end
  endtask
  task t_id;
  begin
    run(1'b0, 3'h3, 5'h1);
    check("maker", maker_code_o, MAKER);
    check("part", part_code_o, PART);
    check("id pulses", pulses, 8'h0);
  end
  endtask
  task t_clean;
  begin
    run(1'b1, 3'h3, 5'h1);
    check("pulses", pulses, 8'h8);
    check("pass", {7'h0, pass_o}, 8'h1);
    check("last addr", {5'h0, src_addr_o}, 8'h7);
    for (i = 0; i < 8; i = i + 1)
      check("byte", mdl_u.mem[i], {1'b0, i[2:0], 4'h6});
  end
  endtask
  task t_slow;
  begin
    run(1'b1, 3'h3, 5'h4);
    check("slow pulses", pulses, 8'hb);
    check("slow pass", {7'h0, pass_o}, 8'h1);
  end
  endtask
  task t_dead;
  begin
    run(1'b1, 3'h7, 5'hc);
    check("dead pulses", pulses, 8'h12);
    check("dead pass", {7'h0, pass_o}, 8'h0);
  end
  endtask
  always @(posedge core_clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    check("idle pins", {chip_en_n_o, out_gate_n_o, core_sup_o, prog_sup_o, done_o, busy_o},
      8'hd4);
    t_id;
    t_clean;
    t_slow;
    t_dead;
    summarize;
  end
endmodule
